// file: sotp_ctrl.sv
// Protected-region mode and lock-register control for a serial flash
// Assumes SPI pins are asynchronous and synchronised here; non-volatile
// storage is modelled by registers plus a factory strap caught after reset
`timescale 1ns/100ps
`default_nettype none
module sotp_ctrl #(
   parameter int PUW_CYC = sotp_pkg::PUW_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Serial pins
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic [3:0] dq_i,
   output logic so_o,
   output logic so_oe_o,
   // Mode and device state
   input wire logic quad_wire_command_mode_i,
   input wire logic busy_i,
   input wire logic factory_lock_strap_i,
   // Decoded command outputs to the array logic
   output logic region_mode_o,
   output logic [7:0] otp_lock_flags_o,
   output logic region_write_ok_o,
   output logic main_write_block_o,
   output logic write_reject_o,
   output logic serial_field_hit_o,
   output logic write_ready_o
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [5:0] sync1_q, sync2_q;
   logic cs_n_q, sck_q;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         // Idle levels: chip select high, clock and data low
         sync1_q <= 6'h00_20;
         sync2_q <= 6'h00_20;
         sck_q <= 1'b0;
      end else begin
         sync1_q <= {cs_n_i, sck_i, dq_i};
         sync2_q <= sync1_q;
         sck_q <= sync2_q[4];
      end
   end
   wire logic cs_n_s = sync2_q[5];
   wire logic sck_s = sync2_q[4];
   wire logic sck_rise = sck_s & ~sck_q;
   wire logic sck_fall = ~sck_s & sck_q;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) cs_n_q <= 1'b1;
      else cs_n_q <= cs_n_s;
   end
   wire logic frame_end = cs_n_s & ~cs_n_q;

   // ---------------------------------------------------------------
   // Shift in opcode, address and data
   // ---------------------------------------------------------------
   logic [7:0] shift_q, opcode_q, data_q;
   logic [3:0] bitcnt_q;
   logic [5:0] bytecnt_q;
   logic [23:0] addr_q;
   wire logic [3:0] step = quad_wire_command_mode_i ? 4'h0_4 : 4'h0_1;
   wire logic [7:0] shift_d = quad_wire_command_mode_i ? {shift_q[3:0], sync2_q[3:0]}
                                                      : {shift_q[6:0], sync2_q[0]};
   wire logic [3:0] bitcnt_nx = bitcnt_q + step;
   wire logic byte_done = sck_rise & ~cs_n_s & (bitcnt_nx == 4'(sotp_pkg::BYTE_BITS));
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || cs_n_s) begin
         shift_q <= 8'h00_00;
         bitcnt_q <= 4'h0_0;
         bytecnt_q <= 6'h00_00;
      end else if (sck_rise) begin
         shift_q <= shift_d;
         bitcnt_q <= byte_done ? 4'h0_0 : bitcnt_nx;
         if (byte_done && bytecnt_q != 6'h00_3F) bytecnt_q <= bytecnt_q + 6'h00_01;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         opcode_q <= 8'h00_00;
         data_q <= 8'h00_00;
         addr_q <= 24'h00_0000;
      end else if (byte_done) begin
         if (bytecnt_q == 6'h00_00) opcode_q <= shift_d;
         else if (bytecnt_q < 6'h00_04) addr_q <= {addr_q[15:0], shift_d};
         data_q <= shift_d;
      end
   end

   // ---------------------------------------------------------------
   // Command classification
   // ---------------------------------------------------------------
   function automatic logic is_modify(input logic [7:0] op);
      is_modify = (op == sotp_pkg::OP_PAGE_PROG) || (op == sotp_pkg::OP_QUAD_PROG) ||
                  (op == sotp_pkg::OP_ERASE_4K) || (op == sotp_pkg::OP_ERASE_32K) ||
                  (op == sotp_pkg::OP_ERASE_64K) || (op == sotp_pkg::OP_ERASE_CHIP);
   endfunction

   // ---------------------------------------------------------------
   // Power-up write delay
   // ---------------------------------------------------------------
   localparam int PUW_W = $clog2(PUW_CYC + 1);
   logic [PUW_W-1:0] puw_q;
   logic ready_q;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         puw_q <= '0;
         ready_q <= 1'b0;
      end else if (!ready_q) begin
         puw_q <= puw_q + 1'b1;
         ready_q <= (puw_q == PUW_W'(PUW_CYC - 1)); // [R17]
      end
   end

   // ---------------------------------------------------------------
   // Mode, lock flags and write decisions
   // ---------------------------------------------------------------
   logic mode_q, factory_q, customer_q, strap_done_q;
   logic wr_ok_q, blk_q, rej_q, ser_q;
   wire logic locked = factory_q | customer_q;
   wire logic whole_bytes = (bitcnt_q == 4'h0_0);
   wire logic done = frame_end & (bytecnt_q != 6'h00_00);
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         factory_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         factory_q <= factory_lock_strap_i; // [R4]
         strap_done_q <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_q <= 1'b0;
         customer_q <= 1'b0;
      end else if (done) begin
         if (opcode_q == sotp_pkg::OP_ENTER) mode_q <= 1'b1; // [R2]
         if (opcode_q == sotp_pkg::OP_EXIT) mode_q <= 1'b0; // [R1]
         // No write enable needed; only bit 1; ignored in region mode [R9] [R6] [R12]
         if (opcode_q == sotp_pkg::OP_LOCK_WR && !mode_q && whole_bytes && ready_q &&
             bytecnt_q == 6'h00_02 && !customer_q && data_q[sotp_pkg::CUSTOMER_BIT])
            customer_q <= 1'b1; // [R5] [R7] [R8] [R10]
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_ok_q <= 1'b0;
         blk_q <= 1'b0;
         rej_q <= 1'b0;
         ser_q <= 1'b0;
      end else begin
         wr_ok_q <= done & mode_q & is_modify(opcode_q) & ~locked & ready_q &
                    (addr_q <= sotp_pkg::REGION_LAST); // [R13] [R15] [R8]
         blk_q <= mode_q; // [R11]
         rej_q <= done & mode_q & (is_modify(opcode_q) & locked |
                  opcode_q == sotp_pkg::OP_STAT1_WR | opcode_q == sotp_pkg::OP_STAT2_WR |
                  opcode_q == sotp_pkg::OP_LOCK_WR); // [R12] [R13]
         ser_q <= mode_q & (addr_q <= sotp_pkg::SERIAL_LAST); // [R16]
      end
   end

   // ---------------------------------------------------------------
   // Lock-register read out, any time, repeating
   // ---------------------------------------------------------------
   wire logic [7:0] flags = {6'h00_00, customer_q, factory_q}; // [R18]
   logic [7:0] out_q;
   logic so_q, oe_q;
   wire logic rd_active = ~cs_n_s & (opcode_q == sotp_pkg::OP_LOCK_RD) &
                          (bytecnt_q != 6'h00_00);
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         out_q <= 8'h00_00;
         so_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         oe_q <= rd_active; // [R3]
         if (byte_done && (bytecnt_q == 6'h00_00 ? shift_d == sotp_pkg::OP_LOCK_RD : rd_active))
            out_q <= flags; // [R3]
         else if (sck_fall && rd_active)
            out_q <= {out_q[6:0], 1'b0};
         if (sck_fall && rd_active) so_q <= out_q[7];
      end
   end

   assign so_o = so_q;
   assign so_oe_o = oe_q;
   assign region_mode_o = mode_q;
   assign otp_lock_flags_o = {6'h00_00, customer_q, factory_q};
   assign region_write_ok_o = wr_ok_q;
   assign main_write_block_o = blk_q;
   assign write_reject_o = rej_q;
   assign serial_field_hit_o = ser_q;
   assign write_ready_o = ready_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_EXIT: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R1]
      done && opcode_q == sotp_pkg::OP_EXIT |=> !mode_q)
      else $error("exit opcode did not leave region mode");

   AST_ENTER: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R2]
      done && opcode_q == sotp_pkg::OP_ENTER |=> mode_q ##1 blk_q)
      else $error("enter opcode did not enter region mode");

   AST_MAIN_BLOCK: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R11]
      mode_q ##1 mode_q |-> main_write_block_o)
      else $error("main array not blocked in region mode");

   AST_MAIN_FREE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R1] [R11]
      !mode_q ##1 !mode_q |-> !main_write_block_o)
      else $error("main array blocked outside region mode");

   // ---------------------------------------------------------------
   // Lock flag checks
   // ---------------------------------------------------------------
   AST_CUST_STICKY: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R7]
      customer_q |=> customer_q)
      else $error("customer lock cleared");

   AST_LOCKWR_PARTIAL: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R10]
      done && !whole_bytes && !customer_q |=> !customer_q)
      else $error("partial lock write executed");

   AST_REGION_IGNORE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R12]
      done && mode_q && opcode_q == sotp_pkg::OP_LOCK_WR |=> rej_q && $stable(customer_q))
      else $error("lock write not ignored in region mode");

   AST_RSVD_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R18]
      otp_lock_flags_o[7:2] == 6'h00_00)
      else $error("reserved lock bits nonzero");

   AST_FACTORY_CATCH: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R4]
      !strap_done_q |=> factory_q == $past(factory_lock_strap_i))
      else $error("factory lock flag not taken from strap");

   AST_FACTORY_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R6] [R8]
      strap_done_q |=> $stable(factory_q))
      else $error("factory lock flag changed");

   AST_CUST_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R5] [R9]
      done && opcode_q == sotp_pkg::OP_LOCK_WR && !mode_q && whole_bytes && ready_q &&
      bytecnt_q == 6'h00_02 && data_q[sotp_pkg::CUSTOMER_BIT] |=> customer_q)
      else $error("lock write did not set customer lock");

   AST_CUST_RULES: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R10] [R12]
      $rose(customer_q) |-> $past(whole_bytes) && !$past(mode_q) && $past(ready_q))
      else $error("customer lock set by a refused write");

   // ---------------------------------------------------------------
   // Write decision checks
   // ---------------------------------------------------------------
   AST_LOCKED_NO_WR: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R8]
      $past(locked) |-> !wr_ok_q)
      else $error("locked region accepted a write");

   AST_REGION_WR_OK: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R2] [R15]
      done && mode_q && is_modify(opcode_q) && !locked && ready_q &&
      addr_q <= sotp_pkg::REGION_LAST |=> region_write_ok_o)
      else $error("unlocked region write not permitted");

   AST_LOCKED_REJECT: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R7] [R13]
      done && mode_q && is_modify(opcode_q) && locked |=> write_reject_o)
      else $error("write to locked region not rejected");

   AST_STATUS_IGNORE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R12]
      done && mode_q && (opcode_q == sotp_pkg::OP_STAT1_WR ||
      opcode_q == sotp_pkg::OP_STAT2_WR) |=> write_reject_o)
      else $error("status write not ignored in region mode");

   AST_REGION_RANGE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R15]
      region_write_ok_o |-> $past(mode_q) && $past(addr_q) <= sotp_pkg::REGION_LAST)
      else $error("region write outside region");

   AST_SERIAL_MAP: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R16]
      serial_field_hit_o |-> $past(mode_q) && $past(addr_q) <= sotp_pkg::SERIAL_LAST)
      else $error("serial field hit outside serial field");

   // ---------------------------------------------------------------
   // Lock read out checks
   // ---------------------------------------------------------------
   AST_READ_OE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R3]
      rd_active |=> so_oe_o)
      else $error("lock read output not enabled");

   AST_READ_BUSY: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R3]
      rd_active && busy_i |=> so_oe_o)
      else $error("lock read blocked while busy");

   AST_READ_SHIFT: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R3]
      sck_fall && rd_active |=> so_o == $past(out_q[7]))
      else $error("lock read bit out of order");

   AST_READ_RELOAD: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R3] [R18]
      byte_done && rd_active |=> out_q == $past(flags))
      else $error("lock read did not repeat the register");

   AST_OE_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R3]
      cs_n_s |=> !so_oe_o)
      else $error("read output enabled while deselected");
endmodule // sotp_ctrl
`default_nettype wire

// file: sotp_pkg.sv
// Constants for the protected-region lock control block
// Assumes a single 125 MHz system clock domain
//
// Contract
// R1: Opcode C1h leaves protected-region mode; accesses return to main array.
// R2: Opcode B1h enters protected-region mode; read and program target region.
// R3: Lock-register read 2Bh accepted anytime, even busy, repeating while clocked.
// R4: Bit 0 is non-volatile factory lock flag, 1 when factory locked.
// R5: Bit 1 is non-volatile customer lock flag, set by lock-register write. Code: rst_i clears it to 0.
// R6: Lock-register write changes only bit 1.
// R7: Once customer flag is 1, refuse flag change and region program/erase.
// R8: Any lock, factory or customer, is permanent; region modification rejected. Code: rst_i clears the customer flag.
// R9: Lock-register write 2Fh needs no preceding write enable.
// R10: Lock-register write not ending on byte boundary is discarded.
// R11: In protected-region mode, writes to main array are blocked.
// R12: In region mode, ignore status writes one and two and lock write.
// R13: Locked region accepts only read-type commands.
// R14: Host programs region by enter, page program, then exit.
// R15: Region holds 4K bits, separate from main array, for serial number.
// R16: Addresses 000000-00000F serial field; 000010-0001FF general area.
// R17: Host waits power-up write delay, 1 to 10 ms, before writes.
// R18: Bits 7 to 2 reserved, read zero, writes ignored.
package sotp_pkg;
   // Opcodes
   localparam logic [7:0] OP_ENTER = 8'h00_B1;
   localparam logic [7:0] OP_EXIT = 8'h00_C1;
   localparam logic [7:0] OP_LOCK_RD = 8'h00_2B;
   localparam logic [7:0] OP_LOCK_WR = 8'h00_2F;
   localparam logic [7:0] OP_STAT1_WR = 8'h00_01;
   localparam logic [7:0] OP_STAT2_WR = 8'h00_31;
   localparam logic [7:0] OP_PAGE_PROG = 8'h00_02;
   localparam logic [7:0] OP_QUAD_PROG = 8'h00_32;
   localparam logic [7:0] OP_ERASE_4K = 8'h00_20;
   localparam logic [7:0] OP_ERASE_32K = 8'h00_52;
   localparam logic [7:0] OP_ERASE_64K = 8'h00_D8;
   localparam logic [7:0] OP_ERASE_CHIP = 8'h00_C7;
   // Lock register fields
   localparam int FACTORY_BIT = 0;
   localparam int CUSTOMER_BIT = 1;
   // Region map
   localparam logic [23:0] REGION_LAST = 24'h00_01FF;
   localparam logic [23:0] SERIAL_LAST = 24'h00_000F;
   localparam int REGION_BITS = 4096;
   // Power-up write delay
   localparam int CLK_MHZ = 125;
   localparam int PUW_MIN_MS = 1;
   localparam int PUW_MAX_MS = 10;
   localparam int PUW_CYCLES = PUW_MIN_MS * 1000 * CLK_MHZ;
   localparam int BYTE_BITS = 8;
endpackage

// file: sotp_host_model.sv
// Host-side serial controller model sending single-wire or quad-wire frames
// Assumes the device samples on sck rise and shifts out on sck fall
`timescale 1ns/100ps
`default_nettype none
module sotp_host_model (
   // Clock
   input wire logic ref_clk_i,
   // Serial pins
   output logic cs_n_o,
   output logic sck_o,
   output logic [3:0] dq_o,
   input wire logic so_i,
   // Mode
   input wire logic quad_i
);
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      dq_o = 4'h0;
   end
   // Sends n bits of d MSB first, a nibble per clock in quad mode; rd keeps the last 8 bits seen
   task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] rd);
      int stp;
      rd = 8'h00;
      stp = quad_i ? 4 : 1;
      cs_n_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      for (int i = n - 1; i >= 0; i -= stp) begin
         dq_o <= quad_i ? d[i -: 4] : {3'b000, d[i]};
         repeat (4) @(posedge ref_clk_i);
         sck_o <= 1'b1;
         rd = {rd[6:0], so_i};
         repeat (4) @(posedge ref_clk_i);
         sck_o <= 1'b0;
      end
      // Chip select rises after the last bit, byte aligned or not
      repeat (4) @(posedge ref_clk_i);
      cs_n_o <= 1'b1;
      dq_o <= ~dq_o;
      repeat (6) @(posedge ref_clk_i);
   endtask
endmodule // sotp_host_model
`default_nettype wire

// file: sotp_ctrl_tb_top.sv
// Self-checking bench for the protected-region lock control block
// Assumes the host model drives the serial pins in single-wire mode, and in quad-wire mode for one enter and exit pair
`timescale 1ns/100ps
`default_nettype none
module sotp_ctrl_tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic busy = 1'b0;
   logic quad = 1'b0;
   logic strap = 1'b0;
   wire logic cs_n;
   wire logic sck;
   wire logic [3:0] dq;
   logic so, so_oe, region, wr_ok, main_blk, rej, ser_hit, wr_rdy;
   logic [7:0] flags;
   logic [7:0] rd;
   logic rej_seen = 1'b0;
   logic ok_seen = 1'b0;
   logic oe_seen = 1'b0;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   always #4 ref_clk_i = ~ref_clk_i;
   sotp_ctrl #(.PUW_CYC(20)) dut_u (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .dq_i(dq),
      .so_o(so), .so_oe_o(so_oe), .quad_wire_command_mode_i(quad), .busy_i(busy),
      .factory_lock_strap_i(strap), .region_mode_o(region), .otp_lock_flags_o(flags),
      .region_write_ok_o(wr_ok), .main_write_block_o(main_blk), .write_reject_o(rej),
      .serial_field_hit_o(ser_hit), .write_ready_o(wr_rdy));
   sotp_host_model host_u (
      .ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .sck_o(sck), .dq_o(dq), .so_i(so),
      .quad_i(quad));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic fr(input logic [39:0] d, input int n);
      rej_seen = 1'b0;
      ok_seen = 1'b0;
      oe_seen = 1'b0;
      host_u.xfer(d, n, rd);
      repeat (4) @(posedge ref_clk_i);
   endtask
   task automatic rdl(input logic [7:0] exp);
      fr(40'h2B00, 16);
      chk("lock read", rd, exp);
      chk("lock flags", flags, exp);
      chk("read enable", oe_seen, 8'h01);
      chk("read enable idle", so_oe, 8'h00);
   endtask
   always @(posedge ref_clk_i) begin
      cyc++;
      if (rej === 1'b1) rej_seen = 1'b1;
      if (wr_ok === 1'b1) ok_seen = 1'b1;
      if (so_oe === 1'b1) oe_seen = 1'b1;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      chk("write ready", wr_rdy, 8'h00);
      repeat (24) @(posedge ref_clk_i);
      chk("write ready", wr_rdy, 8'h01);
      busy <= 1'b1;
      rdl(8'h00);
      busy <= 1'b0;
      fr(40'hB1, 8);
      chk("region mode", region, 8'h01);
      chk("main block", main_blk, 8'h01);
      fr(40'h2F02, 16);
      chk("lock flags", flags, 8'h00);
      chk("reject", rej_seen, 8'h01);
      fr(40'h3100, 16);
      chk("reject", rej_seen, 8'h01);
      fr(40'h02_0000_05A5, 40);
      chk("region write", ok_seen, 8'h01);
      chk("serial hit", ser_hit, 8'h01);
      fr(40'h02_0001_FFA5, 40);
      chk("serial hit", ser_hit, 8'h00);
      fr(40'hC1, 8);
      chk("region mode", region, 8'h00);
      chk("main block", main_blk, 8'h00);
      quad <= 1'b1;
      @(posedge ref_clk_i);
      fr(40'hB1, 8);
      chk("quad region mode", region, 8'h01);
      fr(40'hC1, 8);
      chk("quad region mode", region, 8'h00);
      quad <= 1'b0;
      @(posedge ref_clk_i);
      fr(40'h5E05, 17);
      rdl(8'h00);
      fr(40'h2FFF, 16);
      rdl(8'h02);
      fr(40'h2F00, 16);
      rdl(8'h02);
      fr(40'hB1, 8);
      fr(40'h02_0000_05A5, 40);
      chk("region write", ok_seen, 8'h00);
      chk("reject", rej_seen, 8'h01);
      fr(40'hC1, 8);
      strap <= 1'b1;
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (30) @(posedge ref_clk_i);
      rdl(8'h01);
      fr(40'hB1, 8);
      fr(40'h02_0000_20A5, 40);
      chk("region write", ok_seen, 8'h00);
      chk("reject", rej_seen, 8'h01);
      close_out();
   end
endmodule // sotp_ctrl_tb_top
`default_nettype wire
